// ---- fault_aggregation_and_indication_tb.sv ----
// Purpose: self-checking bench for the fault aggregator
// Assumes: heartbeat half period shortened to 2 cycles
// Notes:   alarm pin has a pull-up, so released it reads 1
`timescale 1ns/1ps
module fault_aggregation_and_indication_tb;
	localparam logic [7:0] DET = fault_pkg::OFF_DETAIL_0;
	localparam logic [7:0] STA = fault_pkg::OFF_MAIN_STATUS;
	localparam logic [7:0] PIN = fault_pkg::OFF_PIN_CFG;
	localparam logic [7:0] IND = fault_pkg::OFF_INDICATORS;
	logic clock, sys_rst, writeStrobe, readStrobe, crcMismatch;
	logic lockState, clockSource, muxConverterSequenceRunning;
	logic otpLoadDone, otpLoadOk, otpLoadStart, otpLoadBank;
	logic alarmPinOut, alarmPinOe_n;
	logic [7:0] address;
	logic [31:0] writeData, readData;
	logic [3:0] commandResponse;
	logic [1:0] operatingMode, failMask, mapChecksumInjectPattern;
	logic [31:0] monitorFault [8];
	logic [31:0] monitorEnable [8];
	logic [31:0] monitorSelftest [8];
	int n_fail, n_compared;
	wire alarmPinIn = alarmPinOe_n ? 1'b1 : alarmPinOut;

	fault_aggregator #(
		.HB_HALF (2)
	) dut (
		.clock                       (clock),
		.sys_rst                     (sys_rst),
		.address                     (address),
		.writeData                   (writeData),
		.writeStrobe                 (writeStrobe),
		.readStrobe                  (readStrobe),
		.readData                    (readData),
		.monitorFault                (monitorFault),
		.crcMismatch                 (crcMismatch),
		.commandResponse             (commandResponse),
		.lockState                   (lockState),
		.clockSource                 (clockSource),
		.operatingMode               (operatingMode),
		.muxConverterSequenceRunning (muxConverterSequenceRunning),
		.otpLoadDone                 (otpLoadDone),
		.otpLoadOk                   (otpLoadOk),
		.alarmPinIn                  (alarmPinIn),
		.alarmPinOut                 (alarmPinOut),
		.alarmPinOe_n                (alarmPinOe_n),
		.monitorEnable               (monitorEnable),
		.monitorSelftest             (monitorSelftest),
		.mapChecksumInjectPattern    (mapChecksumInjectPattern),
		.otpLoadStart                (otpLoadStart),
		.otpLoadBank                 (otpLoadBank)
	);
	otp_bank_model bank (
		.clock        (clock),
		.sys_rst      (sys_rst),
		.otpLoadStart (otpLoadStart),
		.otpLoadBank  (otpLoadBank),
		.failMask     (failMask),
		.otpLoadDone  (otpLoadDone),
		.otpLoadOk    (otpLoadOk)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clock);
		writeStrobe <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, exp);
		address <= a;
		readStrobe <= 1'b1;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1 chk(readData & m, exp);
		@(posedge clock);
	endtask
	task automatic pulse(input int g, input logic [31:0] bits);
		monitorFault[g] <= bits;
		repeat (3) @(posedge clock);
		monitorFault[g] <= 32'h0;
		repeat (3) @(posedge clock);
	endtask
	task automatic pin(input logic [1:0] exp);
		repeat (3) @(posedge clock);
		#1 chk({30'h0, alarmPinOe_n, alarmPinOut}, {30'h0, exp});
		@(posedge clock);
	endtask
	task automatic ones(input int exp);
		int n;
		n = 0;
		repeat (3) @(posedge clock);
		repeat (8) begin
			@(posedge clock);
			#1 n += int'(alarmPinOut);
		end
		chk(n, exp);
		@(posedge clock);
	endtask
	task automatic do_reset();
		sys_rst <= 1'b1;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (20) @(posedge clock);
	endtask
	task automatic ind(input logic [3:0] r, input logic [4:0] v,
		input logic [31:0] exp);
		commandResponse <= r;
		{lockState, clockSource, operatingMode} <= v[4:1];
		muxConverterSequenceRunning <= v[0];
		repeat (3) @(posedge clock);
		rd(IND, 32'h1FF, exp);
		rd(STA, 32'hF, {28'h0, r});
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		rd(STA, 32'h7F80, 32'h7F80);
		rd(DET, 32'hFFFFFFFF, fault_pkg::DETAIL_RESET);
		rd(fault_pkg::OFF_MASK_0, 32'hFFFFFFFF, fault_pkg::MASK_RESET);
		rd(PIN, 32'hFF1F, 32'h0010);
		rd(8'hFC, 32'hFFFFFFFF, 32'h0);
	endtask
	task automatic t_clear();
		pulse(0, 32'h1);
		rd(DET, 32'h1, 32'h1);
		rd(STA, 32'h80, 32'h80);
		wr(fault_pkg::OFF_ENABLE_0, 32'h1);
		pulse(0, 32'h1);
		rd(DET, 32'h1, 32'h0);
		wr(STA, 32'h80);
		rd(STA, 32'h80, 32'h0);
		wr(DET, 32'h1);
		wr(STA, 32'h80);
		rd(STA, 32'h80, 32'h80);
	endtask
	task automatic t_mask();
		wr(fault_pkg::OFF_ENABLE_0 + 8'h4, 32'h2);
		wr(fault_pkg::OFF_MASK_0 + 8'h4, 32'h2);
		pulse(1, 32'h2);
		rd(DET + 8'h4, 32'h2, 32'h0);
		rd(STA, 32'h100, 32'h100);
		wr(fault_pkg::OFF_MASK_0 + 8'h4, 32'h0);
		pulse(1, 32'h2);
		rd(STA, 32'h100, 32'h0);
		wr(DET + 8'h4, 32'h2);
		wr(STA, 32'h100);
	endtask
	task automatic t_selftest();
		wr(fault_pkg::OFF_ENABLE_0, 32'h4);
		wr(fault_pkg::OFF_SELFTEST_0, 32'h4);
		repeat (4) @(posedge clock);
		chk(monitorEnable[0], 32'h4);
		chk(monitorSelftest[0], 32'h4);
		wr(fault_pkg::OFF_ENABLE_0, 32'h0);
		wr(fault_pkg::OFF_SELFTEST_0, 32'h0);
		rd(DET, 32'h4, 32'h0);
		wr(DET, 32'h4);
		wr(STA, 32'h80);
		rd(DET, 32'h4, 32'h4);
	endtask
	task automatic t_alarm();
		wr(fault_pkg::OFF_ENABLE_0 + 8'h8, 32'h1);
		wr(PIN, 32'h1);
		pin(2'b01);
		pulse(2, 32'h1);
		pin(2'b00);
		wr(PIN, 32'h9);
		pin(2'b01);
		wr(DET + 8'h8, 32'h1);
		wr(STA, 32'h200);
		pin(2'b00);
		wr(PIN, 32'h5);
		ones(4);
		pulse(2, 32'h1);
		ones(0);
		wr(PIN, 32'hFF01);
		pin(2'b01);
		wr(PIN, 32'h3);
		pin(2'b11);
		wr(DET + 8'h8, 32'h1);
		wr(STA, 32'h200);
		wr(PIN, 32'h0);
	endtask
	task automatic t_otp();
		failMask <= 2'b01;
		do_reset();
		rd(IND, 32'h80000400, 32'h80000400);
		rd(DET + 8'h1C, 32'h1, 32'h1);
		failMask <= 2'b11;
		do_reset();
		rd(DET + 8'h1C, 32'h1, 32'h0);
		failMask <= 2'b00;
		do_reset();
		rd(IND, 32'h80000400, 32'h400);
		crcMismatch <= 1'b1;
		@(posedge clock);
		crcMismatch <= 1'b0;
		rd(DET + 8'h1C, 32'h1, 32'h0);
		rd(IND, 32'h200, 32'h0);
	endtask

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Whole run needs well under ten thousand cycles
	initial begin
		#50000;
		n_fail++;
		final_report();
	end
	initial begin
		n_fail = 0;
		n_compared = 0;
		{sys_rst, writeStrobe, readStrobe, crcMismatch} = 4'h8;
		{lockState, clockSource, muxConverterSequenceRunning} = 3'h0;
		{address, writeData, commandResponse} = 44'h0;
		{operatingMode, failMask} = 4'h0;
		foreach (monitorFault[i]) monitorFault[i] = 32'h0;
		do_reset();
		t_reset();
		t_clear();
		t_mask();
		t_selftest();
		t_alarm();
		for (int p = 0; p < 4; p++) begin
			wr(fault_pkg::OFF_CRC_DIAG, 32'(p));
			#1 chk({30'h0, mapChecksumInjectPattern}, 32'(p));
			@(posedge clock);
		end
		ind(4'hA, 5'b10101, 32'h19A);
		ind(4'h5, 5'b01010, 32'h065);
		t_otp();
		final_report();
	end
endmodule

// ---- fault_aggregator.sv ----
// Purpose: detailed fault flags, summary flags, alarm pin and indicators
// Assumes: monitors report raw active-high fault conditions
// Notes:   flags are active low and sticky until written with 1; summary flags also need all unmasked detail flags of the group at 1
`timescale 1ns/1ps

module fault_aggregator #(
	parameter int FLAGS    = fault_pkg::FLAGS,
	parameter int HB_HALF  = fault_pkg::HEARTBEAT_HALF
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  address,
	input  wire logic [31:0] writeData,
	input  wire logic        writeStrobe,
	input  wire logic        readStrobe,
	output logic [31:0]      readData,
	input  wire logic [31:0] monitorFault [FLAGS],
	input  wire logic        crcMismatch,
	input  wire logic [3:0]  commandResponse,
	input  wire logic        lockState,
	input  wire logic        clockSource,
	input  wire logic [1:0]  operatingMode,
	input  wire logic        muxConverterSequenceRunning,
	input  wire logic        otpLoadDone,
	input  wire logic        otpLoadOk,
	input  wire logic        alarmPinIn,
	output logic             alarmPinOut,
	output logic             alarmPinOe_n,
	output logic [31:0]      monitorEnable [FLAGS],
	output logic [31:0]      monitorSelftest [FLAGS],
	output logic [1:0]       mapChecksumInjectPattern,
	output logic             otpLoadStart,
	output logic             otpLoadBank
);
	// ****************************************************************
	// Register state
	// ****************************************************************
	logic [31:0] detail    [FLAGS];
	logic [31:0] enable    [FLAGS];
	logic [31:0] mask      [FLAGS];
	logic [31:0] selftest  [FLAGS];
	logic [FLAGS-1:0] summaryN;
	logic [31:0] pinCfg;
	logic [1:0]  crcDiag;
	logic        crcErrorN;
	logic [2:0]  pinSync;
	logic        pinLevel;
	logic        heartbeat;
	logic        bankUsed;
	logic        loadFailed;
	logic        loadFinished;
	logic        loadStart;
	logic        loadBank;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire         wrMain  = writeStrobe &&
		address == fault_pkg::OFF_MAIN_STATUS;
	wire         wrPin   = writeStrobe &&
		address == fault_pkg::OFF_PIN_CFG;
	wire         wrCrc   = writeStrobe &&
		address == fault_pkg::OFF_CRC_DIAG;
	wire [FLAGS-1:0] wrDetail;
	wire [FLAGS-1:0] wrEnable;
	wire [FLAGS-1:0] wrMask;
	wire [FLAGS-1:0] wrSelftest;
	wire [FLAGS-1:0] groupClean;
	wire [FLAGS-1:0] groupFault;
	wire [31:0]  crcEvent;

	// Checksum error lands in the digital group, entry FLAGS-1
	assign crcEvent = {31'h00000000, crcMismatch || loadFailed};

	genvar g;
	generate
		for (g = 0; g < FLAGS; g++) begin : group
			localparam logic [7:0] IDX = 8'(g * 4);
			wire [31:0] raw;
			wire [31:0] hit;
			assign wrDetail[g]   = writeStrobe &&
				address == fault_pkg::OFF_DETAIL_0 + IDX;
			assign wrEnable[g]   = writeStrobe &&
				address == fault_pkg::OFF_ENABLE_0 + IDX;
			assign wrMask[g]     = writeStrobe &&
				address == fault_pkg::OFF_MASK_0 + IDX;
			assign wrSelftest[g] = writeStrobe &&
				address == fault_pkg::OFF_SELFTEST_0 + IDX;
			// Self-test forces the fault input of an enabled monitor
			assign raw = enable[g] &
				(monitorFault[g] | selftest[g]);
			assign hit = (g == FLAGS - 1) ? (raw | crcEvent) : raw;
			assign groupClean[g] = &(detail[g] | mask[g]);
			assign groupFault[g] = |(hit & ~mask[g]);

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					detail[g] <= fault_pkg::DETAIL_RESET;
				end else begin
					// Set wins over a clearing write in the same cycle
					detail[g] <= (detail[g] |
						(wrDetail[g] ? writeData : 32'h00000000)) &
						~hit;
				end
			end

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					enable[g]   <= fault_pkg::ENABLE_RESET;
					mask[g]     <= fault_pkg::MASK_RESET;
					selftest[g] <= 32'h00000000;
				end else begin
					if (wrEnable[g])
						enable[g] <= writeData;
					if (wrMask[g])
						mask[g] <= writeData;
					if (wrSelftest[g])
						selftest[g] <= writeData;
				end
			end

			always_ff @(posedge clock) begin
				if (sys_rst) begin
					summaryN[g] <= 1'b1;
				end else if (groupFault[g]) begin
					summaryN[g] <= 1'b0;
				end else if (wrMain &&
					writeData[fault_pkg::SUMMARY_LSB + g] &&
					groupClean[g]) begin
					summaryN[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Configuration and checksum flag
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pinCfg  <= fault_pkg::PIN_RESET;
			crcDiag <= 2'h0;
		end else begin
			if (wrPin)
				pinCfg <= writeData;
			if (wrCrc)
				crcDiag <= writeData[1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			crcErrorN <= 1'b1;
		else
			crcErrorN <= ~detail[FLAGS-1][fault_pkg::CRC_FLAG_BIT]
				? 1'b0 : 1'b1;
	end

	// ****************************************************************
	// Alarm pin
	// ****************************************************************
	wire [FLAGS-1:0] pinMask = pinCfg[fault_pkg::PIN_MASK_LSB +: FLAGS];
	wire alarmActive = |(~summaryN & ~pinMask);
	wire pinIsAlarm  = pinCfg[fault_pkg::PIN_DIR_BIT] &&
		!pinCfg[fault_pkg::PIN_SRC_BIT];
	wire polarity    = pinCfg[fault_pkg::PIN_POL_BIT];
	wire inactiveLvl = pinCfg[fault_pkg::PIN_FMT_BIT] ?
		heartbeat : ~polarity;
	wire nextPin     = alarmActive ? polarity : inactiveLvl;

	heartbeat_gen #(
		.HALF (HB_HALF)
	) u_heartbeat (
		.clock   (clock),
		.sys_rst (sys_rst),
		.wave    (heartbeat)
	);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			alarmPinOut  <= 1'b1;
			alarmPinOe_n <= 1'b1;
		end else begin
			alarmPinOut  <= pinIsAlarm ? nextPin : 1'b1;
			alarmPinOe_n <= ~pinIsAlarm;
		end
	end

	// Pin readback, three stages, change taken when the last two stages agree
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pinSync  <= 3'h0;
			pinLevel <= 1'b0;
		end else begin
			pinSync <= {pinSync[1:0], alarmPinIn};
			if (pinSync[2] == pinSync[1])
				pinLevel <= pinSync[2];
		end
	end

	// ****************************************************************
	// Bank load
	// ****************************************************************
	otp_loader u_loader (
		.clock      (clock),
		.sys_rst    (sys_rst),
		.loadDone   (otpLoadDone),
		.loadOk     (otpLoadOk),
		.loadStart  (loadStart),
		.loadBank   (loadBank),
		.bankUsed   (bankUsed),
		.loadFailed (loadFailed),
		.finished   (loadFinished)
	);

	// ****************************************************************
	// Read port and outputs
	// ****************************************************************
	logic [31:0] mainWord;
	logic [31:0] indicatorWord;
	logic [31:0] readMux;
	logic [31:0] pinWord;

	always_comb begin
		mainWord = 32'h00000000;
		mainWord[fault_pkg::SUMMARY_LSB +: FLAGS] = summaryN;
		mainWord[3:0] = commandResponse;
		indicatorWord = {bankUsed, 20'h00000, loadFinished,
			crcErrorN, muxConverterSequenceRunning,
			operatingMode, clockSource, lockState,
			commandResponse};
		pinWord = pinCfg;
		pinWord[4] = pinLevel;
		readMux = 32'h00000000;
		if (address == fault_pkg::OFF_MAIN_STATUS)
			readMux = mainWord;
		else if (address == fault_pkg::OFF_INDICATORS)
			readMux = indicatorWord;
		else if (address == fault_pkg::OFF_PIN_CFG)
			readMux = pinWord;
		else if (address == fault_pkg::OFF_CRC_DIAG)
			readMux = {30'h00000000, crcDiag};
		for (int i = 0; i < FLAGS; i++) begin
			if (address == fault_pkg::OFF_DETAIL_0 + 8'(i * 4))
				readMux = detail[i];
			if (address == fault_pkg::OFF_ENABLE_0 + 8'(i * 4))
				readMux = enable[i];
			if (address == fault_pkg::OFF_MASK_0 + 8'(i * 4))
				readMux = mask[i];
			if (address == fault_pkg::OFF_SELFTEST_0 + 8'(i * 4))
				readMux = selftest[i];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			readData                 <= 32'h00000000;
			mapChecksumInjectPattern <= 2'h0;
			otpLoadStart             <= 1'b0;
			otpLoadBank              <= 1'b0;
		end else begin
			readData                 <= readStrobe ? readMux : 32'h00000000;
			mapChecksumInjectPattern <= crcDiag;
			otpLoadStart             <= loadStart;
			otpLoadBank              <= loadBank;
		end
	end

	always_ff @(posedge clock) begin
		for (int i = 0; i < FLAGS; i++) begin
			if (sys_rst) begin
				monitorEnable[i]   <= 32'h00000000;
				monitorSelftest[i] <= 32'h00000000;
			end else begin
				monitorEnable[i]   <= enable[i];
				monitorSelftest[i] <= selftest[i];
			end
		end
	end
endmodule

// ---- fault_aggregator_properties.sv ----
// Purpose: port properties of the fault aggregator
// Assumes: pin setup and pattern are shadowed from bus writes
// Notes:   pin checks wait three cycles after a setup write
`timescale 1ns/1ps
module fault_aggregator_checker (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic [7:0]  address,
	input wire logic [31:0] writeData,
	input wire logic        writeStrobe,
	input wire logic        readStrobe,
	input wire logic [31:0] readData,
	input wire logic        alarmPinOut,
	input wire logic        alarmPinOe_n,
	input wire logic [1:0]  mapChecksumInjectPattern,
	input wire logic        otpLoadDone,
	input wire logic        otpLoadOk,
	input wire logic        otpLoadStart,
	input wire logic        otpLoadBank
);
	logic [31:0] pinCfg;
	logic [1:0]  pattern;
	logic [1:0]  cfgAge;
	wire         wrPin = writeStrobe && address == fault_pkg::OFF_PIN_CFG;
	wire         wrPat = writeStrobe && address == fault_pkg::OFF_CRC_DIAG;
	wire         steady = cfgAge == 2'd3;
	wire         alarmMode = pinCfg[0] && !pinCfg[1];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pinCfg <= 32'h0;
			cfgAge <= 2'd0;
		end else if (wrPin) begin
			pinCfg <= writeData;
			cfgAge <= 2'd0;
		end else if (!steady) begin
			cfgAge <= cfgAge + 2'd1;
		end
	end
	always_ff @(posedge clock) begin
		if (wrPat) begin
			pattern <= writeData[1:0];
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence bank0Fail;
		otpLoadDone && !otpLoadOk && !otpLoadBank;
	endsequence
	sequence bank1Start;
		otpLoadStart && otpLoadBank;
	endsequence

	readIdle_a: assert property (!readStrobe |=> readData == 32'h0)
		else $error("read data not zero when idle");
	pinIdle_a: assert property (steady && !alarmMode
		|-> alarmPinOe_n && alarmPinOut) else $error("pin driven");
	pinDrive_a: assert property (steady && alarmMode |-> !alarmPinOe_n)
		else $error("alarm pin not driven");
	alarmMask_a: assert property (steady && alarmMode
		&& pinCfg[15:8] == 8'hFF && !pinCfg[2] |-> alarmPinOut == !pinCfg[3])
		else $error("masked alarm shows active");
	patternCopy_a: assert property (wrPat
		|-> ##[1:2] mapChecksumInjectPattern == pattern)
		else $error("pattern not applied");
	loadStart_a: assert property ($fell(sys_rst) |-> ##[0:2] otpLoadStart)
		else $error("no bank load after reset");
	bankRetry_a: assert property (bank0Fail |-> ##[1:3] bank1Start)
		else $error("no retry from bank 1");
	startPulse_a: assert property (otpLoadStart |=> !otpLoadStart)
		else $error("load start longer than one cycle");
endmodule

bind fault_aggregator fault_aggregator_checker checker_i (
	.clock                    (clock),
	.sys_rst                  (sys_rst),
	.address                  (address),
	.writeData                (writeData),
	.writeStrobe              (writeStrobe),
	.readStrobe               (readStrobe),
	.readData                 (readData),
	.alarmPinOut              (alarmPinOut),
	.alarmPinOe_n             (alarmPinOe_n),
	.mapChecksumInjectPattern (mapChecksumInjectPattern),
	.otpLoadDone              (otpLoadDone),
	.otpLoadOk                (otpLoadOk),
	.otpLoadStart             (otpLoadStart),
	.otpLoadBank              (otpLoadBank)
);

// ---- fault_pkg.sv ----
// Purpose: shared constants for the fault aggregation block
// Assumes: 32-bit register port, word offsets given as byte addresses
// Notes:   all flags are active low, 1 means no fault
package fault_pkg;
	localparam int FLAGS = 8;
	localparam logic [7:0] OFF_MAIN_STATUS = 8'h00;
	localparam logic [7:0] OFF_INDICATORS  = 8'h04;
	localparam logic [7:0] OFF_DETAIL_0    = 8'h10;
	localparam logic [7:0] OFF_ENABLE_0    = 8'h30;
	localparam logic [7:0] OFF_MASK_0      = 8'h50;
	localparam logic [7:0] OFF_SELFTEST_0  = 8'h70;
	localparam logic [7:0] OFF_PIN_CFG     = 8'h90;
	localparam logic [7:0] OFF_CRC_DIAG    = 8'h94;
	localparam int SUMMARY_LSB = 7;
	localparam int PIN_DIR_BIT = 0;
	localparam int PIN_SRC_BIT = 1;
	localparam int PIN_FMT_BIT = 2;
	localparam int PIN_POL_BIT = 3;
	localparam int PIN_MASK_LSB = 8;
	localparam int OTP_BANK_BIT = 31;
	localparam int CRC_FLAG_BIT = 0;
	localparam logic [31:0] DETAIL_RESET = 32'hFFFFFFFF;
	localparam logic [31:0] ENABLE_RESET = 32'h00000000;
	localparam logic [31:0] MASK_RESET   = 32'h00000000;
	localparam logic [31:0] PIN_RESET    = 32'h00000000;
	localparam int HEARTBEAT_NS = 1000;
	localparam int CLOCK_NS = 5;
	localparam int HEARTBEAT_HALF = HEARTBEAT_NS / CLOCK_NS / 2;
	typedef enum {LOAD_BANK0, LOAD_BANK1, LOAD_DONE} load_e;
endpackage

// ---- heartbeat_gen.sv ----
// Purpose: 50% duty square wave for the inactive alarm format
// Assumes: free-running from reset
// Notes:   period is 2*HALF clock cycles
`timescale 1ns/1ps
module heartbeat_gen #(
	parameter int HALF = fault_pkg::HEARTBEAT_HALF
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	output logic      wave
);
	logic [15:0] count;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count <= 16'h0000;
			wave  <= 1'b0;
		end else if (count == 16'(HALF - 1)) begin
			count <= 16'h0000;
			wave  <= ~wave;
		end else begin
			count <= count + 16'h0001;
		end
	end
endmodule

// ---- otp_bank_model.sv ----
// Purpose: bank reader answering the loader's start requests
// Assumes: failMask bit n makes reads of bank n fail
// Notes:   ok wobbles between answers so it is never read stale
`timescale 1ns/1ps
module otp_bank_model #(
	parameter int LATENCY = 3
) (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       otpLoadStart,
	input  wire logic       otpLoadBank,
	input  wire logic [1:0] failMask,
	output logic            otpLoadDone,
	output logic            otpLoadOk
);
	int   count;
	logic bankHeld;

	assign otpLoadOk = otpLoadDone ? !failMask[bankHeld] : count[0];
	always_ff @(posedge clock) begin
		otpLoadDone <= 1'b0;
		if (sys_rst) begin
			count <= 0;
		end else if (otpLoadStart) begin
			count <= LATENCY;
			bankHeld <= otpLoadBank;
		end else if (count != 0) begin
			count <= count - 1;
			otpLoadDone <= count == 1;
		end
	end
endmodule

// ---- otp_loader.sv ----
// Purpose: redundant bank load sequencer after reset
// Assumes: bank reader answers with done and ok pulses
// Notes:   bank 1 is tried only when bank 0 fails
`timescale 1ns/1ps
module otp_loader (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic loadDone,
	input  wire logic loadOk,
	output logic      loadStart,
	output logic      loadBank,
	output logic      bankUsed,
	output logic      loadFailed,
	output logic      finished
);
	fault_pkg::load_e state;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state      <= fault_pkg::LOAD_BANK0;
			loadStart  <= 1'b1;
			loadBank   <= 1'b0;
			bankUsed   <= 1'b0;
			loadFailed <= 1'b0;
			finished   <= 1'b0;
		end else begin
			loadStart <= 1'b0;
			case (state)
			fault_pkg::LOAD_BANK0: begin
				if (loadDone && loadOk) begin
					state    <= fault_pkg::LOAD_DONE;
					finished <= 1'b1;
				end else if (loadDone) begin
					state     <= fault_pkg::LOAD_BANK1;
					loadBank  <= 1'b1;
					loadStart <= 1'b1;
				end
			end
			fault_pkg::LOAD_BANK1: begin
				if (loadDone) begin
					state      <= fault_pkg::LOAD_DONE;
					bankUsed   <= 1'b1;
					loadFailed <= ~loadOk;
					finished   <= 1'b1;
				end
			end
			fault_pkg::LOAD_DONE: state <= fault_pkg::LOAD_DONE;
			default: state <= fault_pkg::LOAD_BANK0;
			endcase
		end
	end
endmodule
